//--- design/sctmr_map.svh
// register-free constants for the capture/compare timer
`ifndef SCTMR_MAP_SVH
`define SCTMR_MAP_SVH
`define SCTMR_ZERO16      16'h0000
`define SCTMR_ONES16      16'hFFFF
`define SCTMR_ONE16       16'h0001
`define SCTMR_MODE_STOP   2'h0
`define SCTMR_MODE_FREE   2'h1
`define SCTMR_MODE_CLR_A  2'h2
`define SCTMR_MODE_CLR_M  2'h3
`define SCTMR_LVL_HOLD    2'h0
`define SCTMR_LVL_LOW     2'h1
`define SCTMR_LVL_HIGH    2'h2
`define SCTMR_EDGE_FALL   2'h0
`define SCTMR_EDGE_RISE   2'h1
`define SCTMR_EDGE_NONE   2'h2
`define SCTMR_EDGE_BOTH   2'h3
`define SCTMR_SRC_DIV2    2'h0
`define SCTMR_SRC_DIV4    2'h1
`define SCTMR_SRC_DIV16   2'h2
`define SCTMR_SRC_PIN_A   2'h3
`define SCTMR_DIV_W       4
`define SCTMR_DIV4_MASK   4'h3
`define SCTMR_DIV2_MASK   4'h1
`define SCTMR_DIV16_MASK  4'hF
`define SCTMR_PHASE_HALF  4'h1
`endif

//--- design/sctmr_pkg.sv
// types shared by the capture/compare timer
package sctmr_pkg;
   // software control word
   typedef struct packed {
      logic [1:0] mode;         // mode_field_high, mode_field_low
      logic [1:0] lvl;          // output_level_set, output_level_reset
      logic       tog_a_en;     // toggle on register-a match
      logic       tog_b_en;     // toggle_on_b_match_enable
      logic       tog_edge_en;  // toggle_on_edge_select
      logic       rev_cap;      // reverse_phase_capture_select
      logic       cap_a_from_b; // register a captures from input b
      logic       cap_a_mode;   // register a is capture (1) or compare (0)
      logic       cap_b_mode;   // register b is capture (1) or compare (0)
      logic [1:0] edge_a;       // edge_select for input a
      logic [1:0] edge_b;       // edge_select for input b
      logic [1:0] src;          // count_source_select
      logic       one_shot_en;  // one-shot output mode
   } sctmr_ctrl_t;
   // one-cycle event pulses
   typedef struct packed {
      logic irq_a;   // interrupt_a
      logic irq_b;   // interrupt_b
      logic ovf;     // counter wrapped
   } sctmr_evt_t;
   typedef enum logic [1:0] {
      SCT_IDLE  = 2'b00,
      SCT_RUN   = 2'b01,
      SCT_PEND  = 2'b11
   } sctmr_state_t;
endpackage

//--- design/sctmr_top.sv
// 16-bit capture/compare timer with toggling output and two capture inputs
// Functional notes
// - level bits: 00 hold, 01 low, 10 high
// - forced level persists and seeds running output
// - nonzero mode starts counter, 00 stops it
// - output inverts on each match interrupt a (tog_a_en set, one-shot off), not on capture interrupt a
// - first match may be one count late
// - capture during read still captures and interrupts
// - registers undefined after stop
// - overflow also on ffff match clear
// - overflow clear ignored before count reaches 0001
// - one-shot only in free and clear-on-edge modes
// - input a counting spoils input a captures
// - capture on count fall, interrupt next rise
// - reverse capture gives no irq; b edge irqs
// - first enable after reset sees high as rise
// - filter a samples div4 or count clock; filter b samples only the internal count tick
// - edge accepted after two equal samples
// - mode 01 is free-running with wrap
// - mode 10 clears and captures on input a edge
// - match a raises interrupt a, toggles output
`timescale 1ns/1ps
`default_nettype none
`include "sctmr_map.svh"
module sctmr_top
   import sctmr_pkg::*;
(
   // clock and reset
   input  wire logic               CORE_CLK,
   input  wire logic               RESET,
   // software control
   input  wire sctmr_pkg::sctmr_ctrl_t CTRL,
   input  wire logic               CMP_A_WR,
   input  wire logic               CMP_B_WR,
   input  wire logic [15:0]        CMP_WDATA,
   input  wire logic               OVF_CLR,
   input  wire logic               ONE_SHOT_TRIG,
   // external pins
   input  wire logic               CAPTURE_INPUT_A,
   input  wire logic               CAPTURE_INPUT_B,
   output logic                    TIMER_OUTPUT_PIN,
   // status
   output logic [15:0]             MAIN_COUNTER,
   output logic [15:0]             CAPCOMP_REG_A,
   output logic [15:0]             CAPCOMP_REG_B,
   output logic                    OVERFLOW_FLAG,
   output logic                    INTERRUPT_A,
   output logic                    INTERRUPT_B
);
   import sctmr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // decoding helpers
   // true when a filtered level change matches the selected edge
   function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                     input logic fall);
      unique case (sel)
         `SCTMR_EDGE_FALL: edge_hit = fall;
         `SCTMR_EDGE_RISE: edge_hit = rise;
         `SCTMR_EDGE_BOTH: edge_hit = rise | fall;
         default:          edge_hit = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers (three flops, change once stages two and three agree)
   logic [2:0] sync_a_q;              // input a pipeline
   logic [2:0] sync_b_q;              // input b pipeline
   logic       pin_a_q;               // accepted level of input a
   logic       pin_b_q;               // accepted level of input b
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         sync_a_q <= 3'h0;
         sync_b_q <= 3'h0;
         pin_a_q  <= 1'b0;
         pin_b_q  <= 1'b0;
      end else begin
         sync_a_q <= {sync_a_q[1:0], CAPTURE_INPUT_A};
         sync_b_q <= {sync_b_q[1:0], CAPTURE_INPUT_B};
         if (sync_a_q[2] == sync_a_q[1]) begin
            pin_a_q <= sync_a_q[2];
         end
         if (sync_b_q[2] == sync_b_q[1]) begin
            pin_b_q <= sync_b_q[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // prescaler: count enable and div4 sampling enable
   logic [`SCTMR_DIV_W-1:0] div_q;    // free-running divider
   logic                    div4_en;  // main clock / 4 pulse
   logic                    int_tick; // internal count pulse
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + `SCTMR_DIV_W'(1);
      end
   end
   assign div4_en = ((div_q & `SCTMR_DIV4_MASK) == `SCTMR_DIV4_MASK);
   always_comb begin
      unique case (CTRL.src)
         `SCTMR_SRC_DIV2:  int_tick = ((div_q & `SCTMR_DIV2_MASK) == `SCTMR_DIV2_MASK);
         `SCTMR_SRC_DIV4:  int_tick = div4_en;
         `SCTMR_SRC_DIV16: int_tick = (div_q == `SCTMR_DIV16_MASK);
         default:          int_tick = 1'b0;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   // noise filters: accept a level after two equal samples
   logic       pin_a_as_clk;          // input a selected as count clock
   logic       samp_a;                // sampling enable for input a
   logic [1:0] flt_a_q;               // input a samples
   logic [1:0] flt_b_q;               // input b samples
   logic       lvl_a_q;               // filtered level a
   logic       lvl_b_q;               // filtered level b
   logic       armed_q;               // first enable since reset pending
   logic       running;
   assign pin_a_as_clk = (CTRL.src == `SCTMR_SRC_PIN_A);
   assign samp_a  = pin_a_as_clk ? div4_en : int_tick;
   assign running = (CTRL.mode != `SCTMR_MODE_STOP);
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         flt_a_q <= 2'h0;
         flt_b_q <= 2'h0;
         lvl_a_q <= 1'b0;
         lvl_b_q <= 1'b0;
      end else begin
         if (samp_a) begin
            flt_a_q <= {flt_a_q[0], pin_a_q};
            if (flt_a_q[0] == pin_a_q) begin
               lvl_a_q <= pin_a_q;
            end
         end
         if (int_tick) begin
            flt_b_q <= {flt_b_q[0], pin_b_q};
            if (flt_b_q[0] == pin_b_q) begin
               lvl_b_q <= pin_b_q;
            end
         end
      end
   end

   // edge detection; the first enable after reset sees a high level as rise
   logic prev_a_q, prev_b_q;          // levels at last check
   logic rise_a, fall_a, rise_b, fall_b;
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         prev_a_q <= 1'b0;
         prev_b_q <= 1'b0;
         armed_q  <= 1'b1;
      end else if (!running) begin
         // track the levels while stopped so a re-enable sees no edge
         prev_a_q <= armed_q ? 1'b0 : lvl_a_q;
         prev_b_q <= armed_q ? 1'b0 : lvl_b_q;
      end else begin
         armed_q  <= 1'b0;
         prev_a_q <= lvl_a_q;
         prev_b_q <= lvl_b_q;
      end
   end
   assign rise_a = running &  lvl_a_q & ~prev_a_q;
   assign fall_a = running & ~lvl_a_q &  prev_a_q;
   assign rise_b = running &  lvl_b_q & ~prev_b_q;
   assign fall_b = running & ~lvl_b_q &  prev_b_q;

   logic val_a, rev_a, val_b;         // valid and opposite edges
   assign val_a = edge_hit(CTRL.edge_a, rise_a, fall_a);
   assign rev_a = edge_hit(CTRL.edge_a, fall_a, rise_a);
   assign val_b = edge_hit(CTRL.edge_b, rise_b, fall_b);

   ////////////////////////////////////////////////////////////////////////
   // count tick selection
   logic tick;
   assign tick = pin_a_as_clk ? val_a : int_tick;

   ////////////////////////////////////////////////////////////////////////
   // run state: first tick after start only synchronises (start error)
   sctmr_state_t st_q;
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         st_q <= SCT_IDLE;
      end else begin
         unique case (st_q)
            SCT_IDLE: if (running) st_q <= SCT_PEND;
            SCT_PEND: if (!running) st_q <= SCT_IDLE;
                      else if (tick) st_q <= SCT_RUN;
            SCT_RUN:  if (!running) st_q <= SCT_IDLE;
            default:  st_q <= SCT_IDLE;
         endcase
      end
   end
   logic cnt_en;
   assign cnt_en = (st_q == SCT_RUN) & tick;

   ////////////////////////////////////////////////////////////////////////
   // main counter
   logic [15:0] cnt_q, cnt_d;
   logic        match_a, match_b, clr_m, clr_e, wrap;
   assign match_a = cnt_en & ~CTRL.cap_a_mode & (cnt_q == CAPCOMP_REG_A);
   assign match_b = cnt_en & ~CTRL.cap_b_mode & (cnt_q == CAPCOMP_REG_B);
   assign clr_m   = match_a & (CTRL.mode == `SCTMR_MODE_CLR_M);
   assign clr_e   = val_a & (CTRL.mode == `SCTMR_MODE_CLR_A) & ~pin_a_as_clk;
   assign wrap    = cnt_en & (cnt_q == `SCTMR_ONES16);
   always_comb begin
      cnt_d = cnt_q;
      if (st_q == SCT_IDLE) begin
         cnt_d = `SCTMR_ZERO16;
      end else if (clr_e | clr_m) begin
         cnt_d = `SCTMR_ZERO16;
      end else if (cnt_en) begin
         cnt_d = cnt_q + `SCTMR_ONE16;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         cnt_q <= `SCTMR_ZERO16;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // capture/compare registers (contents not kept meaningful after stop)
   logic [15:0] reg_a_q, reg_b_q;
   logic        cap_a, cap_b, ext_a, pend_a_q, pend_b_q;
   logic        trig_a;
   assign trig_a = CTRL.cap_a_from_b ? val_b : (CTRL.rev_cap & rev_a);
   // a captures from input a unreliably when input a is the count clock
   assign cap_a  = CTRL.cap_a_mode & trig_a;
   assign cap_b  = CTRL.cap_b_mode & val_a;
   assign ext_a  = CTRL.cap_a_mode & CTRL.rev_cap & ~CTRL.cap_a_from_b & val_b;
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         reg_a_q <= `SCTMR_ZERO16;
         reg_b_q <= `SCTMR_ZERO16;
      end else begin
         if (cap_a) begin
            reg_a_q <= cnt_q;
         end else if (CMP_A_WR) begin
            reg_a_q <= CMP_WDATA;
         end
         if (cap_b) begin
            reg_b_q <= cnt_q;
         end else if (CMP_B_WR) begin
            reg_b_q <= CMP_WDATA;
         end
      end
   end

   // capture interrupts wait for the next count rise
   always_ff @(posedge CORE_CLK) begin
      if (RESET || !running) begin
         pend_a_q <= 1'b0;
         pend_b_q <= 1'b0;
      end else begin
         // reverse-phase capture raises no interrupt a; b edge does
         if ((cap_a & ~CTRL.rev_cap) | ext_a) begin
            pend_a_q <= 1'b1;
         end else if (int_tick | pin_a_as_clk) begin
            pend_a_q <= 1'b0;
         end
         if (cap_b) begin
            pend_b_q <= 1'b1;
         end else if (int_tick | pin_a_as_clk) begin
            pend_b_q <= 1'b0;
         end
      end
   end
   logic irq_a, irq_b;
   assign irq_a = match_a | (pend_a_q & (int_tick | pin_a_as_clk));
   assign irq_b = match_b | (pend_b_q & (int_tick | pin_a_as_clk));

   ////////////////////////////////////////////////////////////////////////
   // overflow flag: set wins over clear, clear ignored until 0001
   logic ovf_q, ovf_hold_q;
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         ovf_q      <= 1'b0;
         ovf_hold_q <= 1'b0;
      end else begin
         if (wrap) begin
            ovf_hold_q <= 1'b1;
         end else if (cnt_en | (st_q == SCT_IDLE)) begin
            ovf_hold_q <= 1'b0;
         end
         if (wrap | ovf_hold_q) begin
            ovf_q <= 1'b1;
         end else if (OVF_CLR) begin
            ovf_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output pin: forced level while stopped, toggles while running
   logic out_q, os_q;
   logic os_ok, os_start, toggle;
   assign os_ok    = CTRL.one_shot_en & (CTRL.mode != `SCTMR_MODE_CLR_M);
   assign os_start = os_ok & ~os_q & (ONE_SHOT_TRIG | (clr_e & CTRL.tog_edge_en));
   assign toggle   = os_ok ? ((os_start) | (os_q & match_b))
                           : ((match_a & CTRL.tog_a_en) | (match_b & CTRL.tog_b_en)
                              | (val_a & CTRL.tog_edge_en));
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         out_q <= 1'b0;
         os_q  <= 1'b0;
      end else if (!running) begin
         os_q <= 1'b0;
         unique case (CTRL.lvl)
            `SCTMR_LVL_LOW:  out_q <= 1'b0;
            `SCTMR_LVL_HIGH: out_q <= 1'b1;
            default:         out_q <= out_q;
         endcase
      end else begin
         if (os_start) begin
            os_q <= 1'b1;
         end else if (os_q & match_b) begin
            os_q <= 1'b0;
         end
         if (toggle) begin
            out_q <= ~out_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         TIMER_OUTPUT_PIN <= 1'b0;
         MAIN_COUNTER     <= `SCTMR_ZERO16;
         CAPCOMP_REG_A    <= `SCTMR_ZERO16;
         CAPCOMP_REG_B    <= `SCTMR_ZERO16;
         OVERFLOW_FLAG    <= 1'b0;
         INTERRUPT_A      <= 1'b0;
         INTERRUPT_B      <= 1'b0;
      end else begin
         TIMER_OUTPUT_PIN <= out_q;
         MAIN_COUNTER     <= cnt_q;
         CAPCOMP_REG_A    <= reg_a_q;
         CAPCOMP_REG_B    <= reg_b_q;
         OVERFLOW_FLAG    <= ovf_q;
         INTERRUPT_A      <= irq_a;
         INTERRUPT_B      <= irq_b;
      end
   end
endmodule
`default_nettype wire

//--- sim/sctmr_pulse_src.sv
// external pulse source model for the two capture input pins
`timescale 1ns/1ps
`default_nettype none
module sctmr_pulse_src (
   // timing reference
   input  wire logic clk,
   // driven capture pins, pulled low while idle
   output logic      pin_a,
   output logic      pin_b
);
   // both pins rest at the pulled-down level
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end
   // set a pin to a steady level just after a falling edge
   task automatic hold(input logic b, input logic v);
      @(negedge clk);
      if (b) begin
         pin_b = v;
      end else begin
         pin_a = v;
      end
   endtask
   // high pulse of w core cycles, then back to the idle level
   task automatic pulse(input logic b, input int w);
      hold(b, 1'b1);
      repeat (w - 1) @(negedge clk);
      hold(b, 1'b0);
   endtask
endmodule
`default_nettype wire

//--- sim/sctmr_properties.sv
// port-level assertions for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module sctmr_properties
   import sctmr_pkg::*;
(
   // clock and reset
   input  wire logic                   CORE_CLK,
   input  wire logic                   RESET,
   // software side
   input  wire sctmr_pkg::sctmr_ctrl_t CTRL,
   input  wire logic                   CMP_B_WR,
   // watched outputs
   input  wire logic                   TIMER_OUTPUT_PIN,
   input  wire logic [15:0]            MAIN_COUNTER,
   input  wire logic [15:0]            CAPCOMP_REG_A,
   input  wire logic [15:0]            CAPCOMP_REG_B,
   input  wire logic                   INTERRUPT_A,
   input  wire logic                   INTERRUPT_B
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   ////////////////////////////////////////////////////////////////////////////////
   // forced levels while stopped
   lvl_low_a: assert property ((CTRL.mode == 2'h0 && CTRL.lvl == 2'h1) [*3]
      |-> !TIMER_OUTPUT_PIN) else $error("pin not low under forced low");
   lvl_high_a: assert property ((CTRL.mode == 2'h0 && CTRL.lvl == 2'h2) [*3]
      |-> TIMER_OUTPUT_PIN) else $error("pin not high under forced high");
   lvl_hold_a: assert property ((CTRL.mode == 2'h0 && CTRL.lvl inside {2'h0, 2'h3}) [*3]
      |-> $stable(TIMER_OUTPUT_PIN)) else $error("pin moved with no forcing");
   ////////////////////////////////////////////////////////////////////////////////
   // counter start and stop
   stop_hold_a: assert property ((CTRL.mode == 2'h0) [*5]
      |-> $stable(MAIN_COUNTER)) else $error("counter moved while stopped");
   step_one_a: assert property ((CTRL.mode == 2'h1 && CTRL.src == 2'h0) [*8]
      |-> 16'(MAIN_COUNTER - $past(MAIN_COUNTER, 2)) == 16'h0001)
      else $error("free count not one per two clocks");
   ////////////////////////////////////////////////////////////////////////////////
   // match and capture events
   match_irq_a: assert property (CTRL.mode == 2'h1 && !CTRL.cap_a_mode && CTRL.src == 2'h0
      && MAIN_COUNTER == CAPCOMP_REG_A && $changed(MAIN_COUNTER) && $stable(CAPCOMP_REG_A)
      |-> ##[0:4] INTERRUPT_A) else $error("no interrupt a after match");
   pin_toggle_a: assert property (INTERRUPT_A && CTRL.tog_a_en && !CTRL.tog_b_en
      && !CTRL.tog_edge_en && !CTRL.one_shot_en && !CTRL.cap_a_mode && CTRL.mode != 2'h0
      |=> TIMER_OUTPUT_PIN != $past(TIMER_OUTPUT_PIN)) else $error("pin not inverted on irq a");
   cap_irq_b_a: assert property (CTRL.mode != 2'h0 && CTRL.cap_b_mode && CTRL.src == 2'h0
      && $changed(CAPCOMP_REG_B) && !$past(CMP_B_WR) && !$past(CMP_B_WR, 2)
      |-> ##[0:6] INTERRUPT_B) else $error("capture b without interrupt b");
   // main scenarios reached
   cover property (INTERRUPT_A && !TIMER_OUTPUT_PIN);
   cover property (CTRL.mode == 2'h2 && INTERRUPT_B);
   cover property (CTRL.cap_a_from_b && INTERRUPT_A);
endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sctmr_pkg::*;
   logic        clk;               // core clock
   logic        rst;               // synchronous reset
   sctmr_ctrl_t ctrl;              // control word
   logic        wr_a;              // register a write strobe
   logic        wr_b;              // register b write strobe
   logic [15:0] wdata;             // write data
   logic        pin;               // timer output pin
   logic [15:0] cnt;               // counter copy
   logic [15:0] reg_a;             // register a copy
   logic [15:0] reg_b;             // register b copy
   logic        irq_a;             // interrupt a pulse
   logic        irq_b;             // interrupt b pulse
   logic        cap_a;             // input a from the source
   logic        cap_b;             // input b from the source
   logic        seen;              // interrupt observed
   logic [15:0] snap;              // sampled counter
   logic        os_trig;           // software one-shot trigger
   logic        ovf;               // overflow flag
   int          n_mismatch;        // mismatches
   int          checks_done;       // comparisons
   int          cycles;            // timeout count
   logic [1:0]  lvl_seq [7] = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h0, 2'h2, 2'h0};
   logic        pin_exp [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   ////////////////////////////////////////////////////////////////////////////////
   sctmr_top dut (
      .CORE_CLK(clk), .RESET(rst), .CTRL(ctrl), .CMP_A_WR(wr_a), .CMP_B_WR(wr_b),
      .CMP_WDATA(wdata), .OVF_CLR(1'b0), .ONE_SHOT_TRIG(os_trig), .CAPTURE_INPUT_A(cap_a),
      .CAPTURE_INPUT_B(cap_b), .TIMER_OUTPUT_PIN(pin), .MAIN_COUNTER(cnt),
      .CAPCOMP_REG_A(reg_a), .CAPCOMP_REG_B(reg_b), .OVERFLOW_FLAG(ovf),
      .INTERRUPT_A(irq_a), .INTERRUPT_B(irq_b)
   );
   // far-side pulse sources
   sctmr_pulse_src src (.clk(clk), .pin_a(cap_a), .pin_b(cap_b));
   // 250 MHz clock
   always #2 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // exact compare, unknowns fail
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // range compare for values carrying the start-up count error
   task automatic chk_in(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi,
                         input string m);
      checks_done++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         n_mismatch++;
         $display("BAD t=%0t %s got %h range %h..%h", $time, m, got, lo, hi);
      end
   endtask
   // bounded wait for an interrupt pulse, sampled between edges
   task automatic wait_irq(input logic b, input int lim, output logic s);
      s = 1'b0;
      for (int i = 0; i < lim && !s; i++) begin
         @(negedge clk);
         s = b ? (irq_b === 1'b1) : (irq_a === 1'b1);
      end
   endtask
   // one-cycle compare register write
   task automatic wr_cmp(input logic b, input logic [15:0] d);
      @(negedge clk);
      wr_a = !b;
      wr_b = b;
      wdata = d;
      @(negedge clk);
      wr_a = 1'b0;
      wr_b = 1'b0;
   endtask
   // reset held six cycles, control cleared
   task automatic do_reset;
      rst = 1'b1;
      ctrl = '0;
      repeat (6) @(negedge clk);
      rst = 1'b0;
   endtask
   // counts, verdict, end of run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ctrl = '0;
      wr_a = 1'b0;
      wr_b = 1'b0;
      wdata = 16'h0000;
      os_trig = 1'b0;
      n_mismatch = 0;
      checks_done = 0;
      cycles = 0;
      do_reset();
      // forced levels, holds and the prohibited code while stopped
      for (int k = 0; k < 7; k++) begin
         ctrl.lvl = lvl_seq[k];
         repeat (4) @(negedge clk);
         chk(16'(pin), 16'(pin_exp[k]), "forced level");
      end
      // free run from a forced high, first match inverts it
      wr_cmp(1'b0, 16'h000A);
      ctrl.tog_a_en = 1'b1;
      ctrl.mode = 2'h1;
      wait_irq(1'b0, 80, seen);
      chk(16'(seen), 16'h0001, "match a irq");
      chk_in(cnt, 16'h000A, 16'h000C, "match count");
      @(negedge clk);
      chk(16'(pin), 16'h0000, "pin after match");
      snap = cnt;
      repeat (10) @(negedge clk);
      chk(16'(cnt - snap), 16'h0005, "free count rate");
      chk(16'(ovf), 16'h0000, "overflow with no wrap");
      // stop clears the counter to zero and holds it there
      ctrl.mode = 2'h0;
      repeat (3) @(negedge clk);
      snap = cnt;
      repeat (20) @(negedge clk);
      chk(cnt, snap, "stopped count");
      // software one-shot in free run: high from trigger to match b
      wr_cmp(1'b1, 16'h0008);
      ctrl.one_shot_en = 1'b1;
      ctrl.mode = 2'h1;
      @(negedge clk);
      os_trig = 1'b1;
      @(negedge clk);
      os_trig = 1'b0;
      repeat (2) @(negedge clk);
      chk(16'(pin), 16'h0001, "one-shot start");
      wait_irq(1'b1, 60, seen);
      repeat (2) @(negedge clk);
      chk(16'(pin), 16'h0000, "one-shot end");
      // clear on match a with nonzero compare values
      ctrl.one_shot_en = 1'b0;
      ctrl.mode = 2'h0;
      repeat (2) @(negedge clk);
      ctrl.mode = 2'h3;
      wait_irq(1'b0, 60, seen);
      repeat (4) @(negedge clk);
      chk_in(cnt, 16'h0000, 16'h0003, "match clear");
      ctrl.mode = 2'h0;
      repeat (2) @(negedge clk);
      // clear and capture on input a, glitch first
      ctrl.cap_b_mode = 1'b1;
      ctrl.edge_a = 2'h1;
      @(negedge clk);
      ctrl.mode = 2'h2;
      repeat (40) @(negedge clk);
      src.pulse(1'b0, 1);
      wait_irq(1'b1, 20, seen);
      chk(16'(seen), 16'h0000, "glitch accepted");
      snap = cnt;
      fork
         src.pulse(1'b0, 12);
         wait_irq(1'b1, 40, seen);
      join
      chk(16'(seen), 16'h0001, "capture irq b");
      chk_in(reg_b, snap, snap + 16'h000A, "captured count");
      chk_in(cnt, 16'h0000, 16'h0003, "cleared count");
      // first enable after reset sees a high input b as rising
      do_reset();
      src.hold(1'b1, 1'b1);
      ctrl.cap_a_mode = 1'b1;
      ctrl.cap_a_from_b = 1'b1;
      ctrl.edge_b = 2'h1;
      repeat (12) @(negedge clk);
      ctrl.mode = 2'h1;
      wait_irq(1'b0, 30, seen);
      chk(16'(seen), 16'h0001, "first enable edge");
      ctrl.mode = 2'h0;
      repeat (4) @(negedge clk);
      ctrl.mode = 2'h1;
      wait_irq(1'b0, 30, seen);
      chk(16'(seen), 16'h0000, "re-enable edge");
      src.hold(1'b1, 1'b0);
      report_and_stop();
   end
endmodule
// port checker beside the timer
bind sctmr_top sctmr_properties chk (
   .CORE_CLK(CORE_CLK), .RESET(RESET), .CTRL(CTRL), .CMP_B_WR(CMP_B_WR),
   .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .MAIN_COUNTER(MAIN_COUNTER),
   .CAPCOMP_REG_A(CAPCOMP_REG_A), .CAPCOMP_REG_B(CAPCOMP_REG_B),
   .INTERRUPT_A(INTERRUPT_A), .INTERRUPT_B(INTERRUPT_B)
);
`default_nettype wire
